// File: bsr_consts.svh
// Offsets, field positions, reset values and counts of the seed bank.
`ifndef BSR_CONSTS_SVH
`define BSR_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define BSR_OFS_LONG_SEED 8'h60
`define BSR_OFS_SHORT_CTRL 8'h62
`define BSR_OFS_TEST_BUS 8'h64
`define BSR_OFS_QUAL_NOISE_A 8'h66
`define BSR_OFS_SIG_NOISE_B 8'h68
`define BSR_OFS_SERVICE_I 8'h6A
`define BSR_OFS_LEN_LOW_Q 8'h6C
`define BSR_OFS_LEN_HIGH_MP 8'h6E
`define BSR_OFS_CRC_LOW_MPCNT 8'h70
`define BSR_OFS_CRC_HIGH_QUAL 8'h72
`define BSR_OFS_TX_POWER 8'h74

// ****************************************************************
// Field positions
// ****************************************************************
`define BSR_SEED_MSB 6
`define BSR_VIEW_BIT 7
`define BSR_SEED_SEL_BIT 3
`define BSR_MP_THR_MSB 7
`define BSR_MP_THR_LSB 5

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define BSR_LONG_SEED_RST 8'h00
`define BSR_SHORT_CTRL_RST 8'h00
`define BSR_MP_DEPTH 15
`define BSR_TXP_SAMPLES 64
`define BSR_TXP_SHIFT 6

`endif

// File: bsr_pkg.sv
// Types shared by the seed and receive status register bank.
package bsr_pkg;

  // Register port request from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bsr_bus_req_type;

  // Live values from the receive datapath.
  typedef struct packed {
    logic [7:0] noise_level_antenna_one;
    logic [7:0] noise_level_antenna_two;
    logic [7:0] snr_quality;
    logic [7:0] signal_field;
    logic [7:0] service_field;
    logic [15:0] length_field;
    logic [15:0] header_crc;
    logic [7:0] i_offset;
    logic [7:0] q_offset;
    logic [7:0] mp_metric;
    logic [7:0] pkt_quality;
  } bsr_rx_stat_type;

  // One transmit power sample, signed.
  typedef struct packed {
    logic [7:0] sample;
    logic valid;
  } bsr_txp_type;

  // Readback view of the read-only registers.
  typedef enum logic {
    BSR_VIEW_B,
    BSR_VIEW_A
  } bsr_view_type;

endpackage : bsr_pkg

// File: bsr_mp_history.sv
// Sliding count of packets with multipath over threshold.
`include "bsr_consts.svh"

module bsr_mp_history (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_push,
  input wire logic i_over,
  output logic [3:0] o_count
);
  import bsr_pkg::*;

  logic [`BSR_MP_DEPTH-1:0] hist_q;
  logic [3:0] count_d;

  // The oldest flag leaves as the newest enters, so the count stays exact.
  always_comb begin
    count_d = o_count;
    if (i_push) begin
      count_d = o_count + 4'(i_over) - 4'(hist_q[`BSR_MP_DEPTH-1]);
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hist_q <= '0;
      o_count <= 4'h0;
    end else if (i_push) begin
      hist_q <= {hist_q[`BSR_MP_DEPTH-2:0], i_over};
      o_count <= count_d;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  AST_MP_COUNT_MATCH: assert property (
    o_count == 4'($countones(hist_q)))
    else $error("Multipath count differs from history.");

endmodule : bsr_mp_history

// File: bsr_seed_regs.sv
// Scrambler seed registers and two-view receive status readback.
//
// Summary of operation
// - Long-preamble seed in bits 6:0 at 0x60.
// - Short-preamble seed and view bit at 0x62.
// - Config bit 3 picks long or short seed.
// - View bit 0 reads b, 1 reads a.
// - 0x64 returns live test bus value.
// - 0x66: noise antenna one or SNR quality.
// - 0x68: noise antenna two or signal field.
// - 0x6A: I DC offset or service field.
// - 0x6C: Q DC offset or length low.
// - 0x6E: multipath metric or length high.
// - 0x70: multipath count of 15 or CRC low.
// - 0x72: packet quality after receive, or CRC high.
// - 0x74: transmit power averaged over 64 samples.
//
// The address-and-strobe port was chosen for this implementation.
`include "bsr_consts.svh"

module bsr_seed_regs (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire bsr_pkg::bsr_bus_req_type i_bus,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_test_bus,
  input wire logic [7:0] i_config_reg_five,
  input wire logic [7:0] i_multipath_threshold_cfg,
  input wire logic i_receive_processing_active,
  input wire logic i_pkt_done,
  input wire bsr_pkg::bsr_rx_stat_type i_rx,
  input wire bsr_pkg::bsr_txp_type i_txp,
  output logic [6:0] o_scrambler_seed,
  output logic o_txp_update
);
  import bsr_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] long_seed_q;
  logic [7:0] short_ctrl_q;
  bsr_view_type view;
  logic [7:0] rdata_d;
  logic active_q;
  logic [7:0] quality_q;
  logic [5:0] txp_cnt_q;
  logic signed [13:0] txp_acc_q;
  logic signed [13:0] txp_sum;
  logic [7:0] txp_avg_q;
  logic mp_over;
  logic [3:0] mp_count;

  // Picks the a view when selected, else the b view.
  function automatic logic [7:0] view_pick(
    input bsr_view_type sel,
    input logic [7:0] a_val,
    input logic [7:0] b_val
  );
    view_pick = (sel == BSR_VIEW_A) ? a_val : b_val;
  endfunction : view_pick

  // True when a write targets the given offset.
  function automatic logic wr_hit(
    input bsr_bus_req_type req,
    input logic [7:0] ofs
  );
    wr_hit = req.wr && (req.addr == ofs);
  endfunction : wr_hit

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      long_seed_q <= `BSR_LONG_SEED_RST;
    end else if (wr_hit(i_bus, `BSR_OFS_LONG_SEED)) begin
      long_seed_q <= i_bus.wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      short_ctrl_q <= `BSR_SHORT_CTRL_RST;
    end else if (wr_hit(i_bus, `BSR_OFS_SHORT_CTRL)) begin
      short_ctrl_q <= i_bus.wdata;
    end
  end

  assign view = bsr_view_type'(short_ctrl_q[`BSR_VIEW_BIT]);

  // ****************************************************************
  // Scrambler seed selection
  // ****************************************************************
  // A set select bit loads the short-preamble seed.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_scrambler_seed <= 7'h00;
    end else if (i_config_reg_five[`BSR_SEED_SEL_BIT]) begin
      o_scrambler_seed <= short_ctrl_q[`BSR_SEED_MSB:0];
    end else begin
      o_scrambler_seed <= long_seed_q[`BSR_SEED_MSB:0];
    end
  end

  // ****************************************************************
  // Packet quality capture
  // ****************************************************************
  // The metric settles only when receive processing ends, so it is
  // taken on that falling edge and held for software.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      active_q <= 1'b0;
    end else begin
      active_q <= i_receive_processing_active;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      quality_q <= 8'h00;
    end else if (active_q && !i_receive_processing_active) begin
      quality_q <= i_rx.pkt_quality;
    end
  end

  // ****************************************************************
  // Multipath history
  // ****************************************************************
  assign mp_over = i_rx.mp_metric[`BSR_MP_THR_MSB:`BSR_MP_THR_LSB] >
    i_multipath_threshold_cfg[`BSR_MP_THR_MSB:`BSR_MP_THR_LSB];

  bsr_mp_history u_mp_history (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_push(i_pkt_done),
    .i_over(mp_over),
    .o_count(mp_count)
  );

  // ****************************************************************
  // Transmit power average
  // ****************************************************************
  assign txp_sum = txp_acc_q + 14'(signed'(i_txp.sample));

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      txp_cnt_q <= 6'h00;
      txp_acc_q <= 14'sh0000;
    end else if (i_txp.valid) begin
      txp_cnt_q <= txp_cnt_q + 6'h01;
      if (txp_cnt_q == 6'(`BSR_TXP_SAMPLES - 1)) begin
        txp_acc_q <= 14'sh0000;
      end else begin
        txp_acc_q <= txp_sum;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      txp_avg_q <= 8'h00;
      o_txp_update <= 1'b0;
    end else begin
      o_txp_update <= 1'b0;
      if (i_txp.valid && txp_cnt_q == 6'(`BSR_TXP_SAMPLES - 1)) begin
        txp_avg_q <= txp_sum[13:`BSR_TXP_SHIFT];
        o_txp_update <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Only the two seed offsets decode writes; the read-only offsets
  // have no write path at all.
  always_comb begin
    rdata_d = 8'h00;
    if (i_bus.rd) begin
      case (i_bus.addr)
        `BSR_OFS_LONG_SEED: rdata_d = long_seed_q;
        `BSR_OFS_SHORT_CTRL: rdata_d = short_ctrl_q;
        `BSR_OFS_TEST_BUS: rdata_d = i_test_bus;
        `BSR_OFS_QUAL_NOISE_A: rdata_d = view_pick(view,
          i_rx.noise_level_antenna_one, i_rx.snr_quality);
        `BSR_OFS_SIG_NOISE_B: rdata_d = view_pick(view,
          i_rx.noise_level_antenna_two, i_rx.signal_field);
        `BSR_OFS_SERVICE_I: rdata_d = view_pick(view,
          i_rx.i_offset, i_rx.service_field);
        `BSR_OFS_LEN_LOW_Q: rdata_d = view_pick(view,
          i_rx.q_offset, i_rx.length_field[7:0]);
        `BSR_OFS_LEN_HIGH_MP: rdata_d = view_pick(view,
          i_rx.mp_metric, i_rx.length_field[15:8]);
        `BSR_OFS_CRC_LOW_MPCNT: rdata_d = view_pick(view,
          {4'h0, mp_count}, i_rx.header_crc[7:0]);
        `BSR_OFS_CRC_HIGH_QUAL: rdata_d = view_pick(view,
          quality_q, i_rx.header_crc[15:8]);
        `BSR_OFS_TX_POWER: rdata_d = txp_avg_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= rdata_d;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  property p_read_gives(logic [7:0] ofs, logic [7:0] val);
    i_bus.rd && i_bus.addr == ofs |=> o_rdata == $past(val);
  endproperty

  AST_LONG_SEED_WRITE: assert property (
    wr_hit(i_bus, `BSR_OFS_LONG_SEED) ##1 i_bus.rd &&
    i_bus.addr == `BSR_OFS_LONG_SEED |=> o_rdata == $past(i_bus.wdata, 2))
    else $error("Long seed readback differs from write.");

  AST_SHORT_SEED_WRITE: assert property (
    wr_hit(i_bus, `BSR_OFS_SHORT_CTRL) |=>
    short_ctrl_q == $past(i_bus.wdata))
    else $error("Short seed register missed a write.");

  AST_SEED_SELECT: assert property (
    $stable(long_seed_q) && $stable(short_ctrl_q) &&
    $stable(i_config_reg_five) [*2] |->
    o_scrambler_seed == (i_config_reg_five[`BSR_SEED_SEL_BIT] ?
      short_ctrl_q[6:0] : long_seed_q[6:0]))
    else $error("Scrambler seed not from the selected register.");

  AST_VIEW_NOISE_A: assert property (
    p_read_gives(`BSR_OFS_QUAL_NOISE_A, short_ctrl_q[7] ?
      i_rx.noise_level_antenna_one : i_rx.snr_quality))
    else $error("Wrong view at the noise or quality location.");

  AST_VIEW_NOISE_B: assert property (
    p_read_gives(`BSR_OFS_SIG_NOISE_B, short_ctrl_q[7] ?
      i_rx.noise_level_antenna_two : i_rx.signal_field))
    else $error("Wrong view at the noise or signal field location.");

  AST_VIEW_SERVICE_I: assert property (
    p_read_gives(`BSR_OFS_SERVICE_I, short_ctrl_q[7] ?
      i_rx.i_offset : i_rx.service_field))
    else $error("Wrong view at the service or offset location.");

  AST_VIEW_LEN_LOW_Q: assert property (
    p_read_gives(`BSR_OFS_LEN_LOW_Q, short_ctrl_q[7] ?
      i_rx.q_offset : i_rx.length_field[7:0]))
    else $error("Wrong view at the length low location.");

  AST_VIEW_LEN_HIGH_MP: assert property (
    p_read_gives(`BSR_OFS_LEN_HIGH_MP, short_ctrl_q[7] ?
      i_rx.mp_metric : i_rx.length_field[15:8]))
    else $error("Wrong view at the length high location.");

  AST_VIEW_CRC_LOW: assert property (
    p_read_gives(`BSR_OFS_CRC_LOW_MPCNT, short_ctrl_q[7] ?
      {4'h0, mp_count} : i_rx.header_crc[7:0]))
    else $error("Wrong view at the checksum low location.");

  AST_VIEW_CRC_HIGH: assert property (
    p_read_gives(`BSR_OFS_CRC_HIGH_QUAL, short_ctrl_q[7] ?
      quality_q : i_rx.header_crc[15:8]))
    else $error("Wrong view at the checksum high location.");

  AST_TEST_BUS: assert property (
    p_read_gives(`BSR_OFS_TEST_BUS, i_test_bus))
    else $error("Test bus readback wrong.");

  AST_TX_POWER_READ: assert property (
    p_read_gives(`BSR_OFS_TX_POWER, txp_avg_q))
    else $error("Power average readback wrong.");

  AST_LONG_SEED_READ: assert property (
    p_read_gives(`BSR_OFS_LONG_SEED, long_seed_q))
    else $error("Long seed readback wrong.");

  AST_SHORT_CTRL_READ: assert property (
    p_read_gives(`BSR_OFS_SHORT_CTRL, short_ctrl_q))
    else $error("Short seed readback wrong.");

  AST_SIGNAL_FIELD: assert property (
    !short_ctrl_q[7] && i_bus.rd &&
    i_bus.addr == `BSR_OFS_SIG_NOISE_B |=>
    o_rdata == $past(i_rx.signal_field))
    else $error("Signal field view wrong.");

  AST_I_OFFSET: assert property (
    short_ctrl_q[7] && i_bus.rd && i_bus.addr == `BSR_OFS_SERVICE_I |=>
    o_rdata == $past(i_rx.i_offset))
    else $error("I offset view wrong.");

  AST_LENGTH_LOW: assert property (
    !short_ctrl_q[7] && i_bus.rd && i_bus.addr == `BSR_OFS_LEN_LOW_Q |=>
    o_rdata == $past(i_rx.length_field[7:0]))
    else $error("Length low view wrong.");

  AST_LENGTH_HIGH: assert property (
    !short_ctrl_q[7] && i_bus.rd &&
    i_bus.addr == `BSR_OFS_LEN_HIGH_MP |=>
    o_rdata == $past(i_rx.length_field[15:8]))
    else $error("Length high view wrong.");

  AST_MP_COUNT_READ: assert property (
    short_ctrl_q[7] && i_bus.rd &&
    i_bus.addr == `BSR_OFS_CRC_LOW_MPCNT |=>
    o_rdata <= 8'(`BSR_MP_DEPTH))
    else $error("Multipath count above its window.");

  AST_QUALITY_HOLD: assert property (
    i_receive_processing_active && active_q |=> $stable(quality_q))
    else $error("Quality metric moved during receive.");

  AST_TXP_PERIOD: assert property (
    o_txp_update |=> !o_txp_update)
    else $error("Power average updated too often.");

  AST_TXP_AFTER_SAMPLES: assert property (
    o_txp_update |->
    $past(i_txp.valid) && $past(txp_cnt_q) == 6'(`BSR_TXP_SAMPLES - 1))
    else $error("Power average updated before its last sample.");

  AST_RO_WRITE: assert property (
    i_bus.wr && i_bus.addr >= `BSR_OFS_TEST_BUS &&
    i_bus.addr <= `BSR_OFS_TX_POWER |=>
    $stable(long_seed_q) && $stable(short_ctrl_q))
    else $error("Write to read-only location changed state.");

  AST_READ_ONLY_ONE_CYCLE: assert property (
    !i_bus.rd |=> o_rdata == 8'h00)
    else $error("Read data outside the read answer cycle.");

  COV_VIEW_A_READ: cover property (
    short_ctrl_q[7] && i_bus.rd && i_bus.addr == `BSR_OFS_QUAL_NOISE_A);
  COV_SHORT_SEED_USED: cover property (
    i_config_reg_five[`BSR_SEED_SEL_BIT] && short_ctrl_q[6:0] != 7'h00);
  COV_TXP_UPDATE: cover property (o_txp_update);
  COV_MP_WINDOW_FULL: cover property (mp_count == 4'(`BSR_MP_DEPTH));
  COV_QUALITY_CAPTURE: cover property (
    active_q && !i_receive_processing_active);

endmodule : bsr_seed_regs

// File: tb_top.sv
// Self-checking testbench for the seed and receive status register bank.
`include "bsr_consts.svh"

module tb_top import bsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  bsr_bus_req_type bus = '0;
  bsr_rx_stat_type rx = '0;
  bsr_txp_type txp = '0;
  logic [7:0] o_rdata, test_bus = 8'h00, cfg5 = 8'h00, mp_cfg = 8'h00;
  logic rx_act = 1'b0, pkt_done = 1'b0, rd_d = 1'b0, txp_upd;
  logic [6:0] seed;
  logic [7:0] ls, ss, s, q;
  logic [7:0] exp_q[$];
  int mismatches = 0, num_checks = 0, sum, w;

  bsr_seed_regs uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_bus(bus),
    .o_rdata(o_rdata), .i_test_bus(test_bus), .i_config_reg_five(cfg5),
    .i_multipath_threshold_cfg(mp_cfg), .i_receive_processing_active(rx_act),
    .i_pkt_done(pkt_done), .i_rx(rx), .i_txp(txp),
    .o_scrambler_seed(seed), .o_txp_update(txp_upd));

  initial begin
    forever #10 i_mclk = ~i_mclk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] e,
                     input string what);
    num_checks++;
    if (got !== e) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what,
               got, e);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask : reg_wr

  // The expected byte is queued; the monitor compares it next cycle.
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge i_mclk);
    bus.rd <= 1'b0;
  endtask : reg_rd

  task automatic pkt(input logic [7:0] m);
    @(posedge i_mclk);
    rx.mp_metric <= m;
    pkt_done <= 1'b1;
    @(posedge i_mclk);
    pkt_done <= 1'b0;
  endtask : pkt

  // ****************************************************************
  // Read data monitor
  // ****************************************************************
  always @(posedge i_mclk) begin
    rd_d <= bus.rd;
  end

  always @(negedge i_mclk) begin
    if (rd_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("wrong value at %0t: read data with nothing queued", $time);
      end else begin
        chk(o_rdata, exp_q.pop_front(), "read data");
      end
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(12));
    repeat (6) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    reg_rd(8'h60, 8'h00);
    reg_rd(8'h62, 8'h00);
    $display("test reset done");

    ls = 8'($urandom);
    ss = 8'($urandom) & 8'h7F;
    reg_wr(8'h60, ls | 8'h80);
    reg_wr(8'h62, ss);
    reg_rd(8'h60, ls | 8'h80);
    reg_rd(8'h62, ss);
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({1'b0, seed}, {1'b0, ls[6:0]}, "long seed");
    @(posedge i_mclk);
    cfg5 <= 8'h08;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({1'b0, seed}, ss, "short seed");
    $display("test seeds done");

    @(posedge i_mclk);
    rx <= bsr_rx_stat_type'({$urandom, $urandom, $urandom, $urandom});
    test_bus <= 8'($urandom);
    mp_cfg <= 8'h60;
    // Let the new inputs settle before their values become expectations.
    @(posedge i_mclk);
    reg_rd(8'h64, test_bus);
    reg_rd(8'h66, rx.snr_quality);
    reg_rd(8'h68, rx.signal_field);
    reg_rd(8'h6A, rx.service_field);
    reg_rd(8'h6C, rx.length_field[7:0]);
    reg_rd(8'h6E, rx.length_field[15:8]);
    reg_rd(8'h70, rx.header_crc[7:0]);
    reg_rd(8'h72, rx.header_crc[15:8]);
    reg_wr(8'h62, ss | 8'h80);
    reg_rd(8'h64, test_bus);
    reg_rd(8'h66, rx.noise_level_antenna_one);
    reg_rd(8'h68, rx.noise_level_antenna_two);
    reg_rd(8'h6A, rx.i_offset);
    reg_rd(8'h6C, rx.q_offset);
    reg_rd(8'h6E, rx.mp_metric);
    reg_rd(8'h70, 8'h00);
    $display("test views done");

    for (int a = 8'h64; a <= 8'h76; a += 2) begin
      reg_wr(8'(a), 8'hFF);
    end
    reg_rd(8'h60, ls | 8'h80);
    reg_rd(8'h62, ss | 8'h80);
    reg_rd(8'h61, 8'h00);
    reg_rd(8'h6A, rx.i_offset);
    $display("test read-only writes done");

    // Seventeen packets over the threshold fill the 15-deep window.
    repeat (17) pkt(8'h80);
    reg_rd(8'h70, 8'h0F);
    repeat (3) pkt(8'h7F);
    reg_rd(8'h70, 8'h0C);
    $display("test multipath count done");

    q = 8'($urandom);
    @(posedge i_mclk);
    rx_act <= 1'b1;
    rx.pkt_quality <= ~q;
    repeat (2) @(posedge i_mclk);
    rx_act <= 1'b0;
    rx.pkt_quality <= q;
    @(posedge i_mclk);
    rx.pkt_quality <= ~q;
    reg_rd(8'h72, q);
    $display("test packet quality done");

    sum = 0;
    for (int k = 0; k < 64; k++) begin
      @(posedge i_mclk);
      s = 8'($urandom);
      txp <= '{sample: s, valid: 1'b1};
      sum += $signed(s);
    end
    @(posedge i_mclk);
    txp.valid <= 1'b0;
    for (w = 0; w < 8 && txp_upd !== 1'b1; w++) begin
      @(negedge i_mclk);
    end
    if (w == 8) begin
      mismatches++;
      $display("wrong value at %0t: no power update", $time);
    end
    @(negedge i_mclk);
    chk({7'h00, txp_upd}, 8'h00, "update pulse length");
    reg_rd(8'h74, 8'(sum >>> 6));
    reg_wr(8'h62, ss);
    reg_rd(8'h74, 8'(sum >>> 6));
    $display("test transmit power done");

    repeat (3) @(posedge i_mclk);
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("wrong value at %0t: reads left unanswered", $time);
    end
    final_report();
  end
endmodule : tb_top
